// ==== src/pdmmic_out.sv ====
module pdmmic_out
    import pdmmic_pkg::*;
#(
    parameter int unsigned WAKE_CNT = WAKE_CYCLES,
    parameter int unsigned SAMP_W   = SAMPLE_W
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_link_clk,
    input  wire logic              i_strap,
    input  wire logic [SAMP_W-1:0] i_sample,
    input  wire logic              i_sample_valid,
    output logic                   o_sample_ready,
    output logic                   o_data_out,
    output logic                   o_data_oe,
    output logic                   o_left_slot,
    output logic                   o_low_power_operation,
    output logic                   o_awake
);
    // ------------------------------------------------------------------
    // Strap capture and slot selection
    // ------------------------------------------------------------------
    logic strap_s1, strap_s2, strap_taken, left_slot, strap_arm1, strap_arm2;
    logic next_strap_taken, next_left_slot;

    // Strap latched once after reset release, then frozen
    // The arm chain waits until the synchroniser holds the real pin level, not its reset value
    always_comb begin
        next_strap_taken = strap_arm2;
        next_left_slot   = strap_taken ? left_slot : (strap_s2 != STRAP_RIGHT);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            strap_s1    <= 1'b0;
            strap_s2    <= 1'b0;
            strap_taken <= 1'b0;
            left_slot   <= 1'b0;
            strap_arm1  <= 1'b0;
            strap_arm2  <= 1'b0;
        end else begin
            strap_s1    <= i_strap;
            strap_s2    <= strap_s1;
            strap_arm1  <= 1'b1;
            strap_arm2  <= strap_arm1;
            strap_taken <= next_strap_taken;
            left_slot   <= next_left_slot;
        end
    end

    // ------------------------------------------------------------------
    // Link clock rate detection
    // ------------------------------------------------------------------
    logic lk_s1, lk_s2, lk_s3;
    logic [CNT_W-1:0] period_cnt, next_period_cnt;
    logic [CNT_W-1:0] last_period, next_last_period;
    logic [31:0]      wake_cnt, next_wake_cnt;
    logic             low_power, next_low_power;
    pdmmic_state_t    state, next_state;
    logic             lk_rise;

    assign lk_rise = lk_s2 & ~lk_s3;

    // Measure link period; sleep when it runs too long
    always_comb begin
        next_period_cnt  = period_cnt;
        next_last_period = last_period;
        next_low_power   = low_power;
        next_wake_cnt    = wake_cnt;
        next_state       = state;
        if (lk_rise) begin
            next_period_cnt  = '0;
            next_last_period = period_cnt;
            next_low_power   = (period_cnt >= CNT_W'(LOWPWR_CYCLES));
        end else if (period_cnt < CNT_W'(SLEEP_CYCLES)) begin
            next_period_cnt = period_cnt + CNT_W'(1);
        end
        case (state)
            PDMMIC_SLEEP: begin
                next_wake_cnt = '0;
                if (lk_rise) next_state = PDMMIC_WAKE;
            end
            PDMMIC_WAKE: begin
                next_wake_cnt = wake_cnt + 32'h1;
                if (period_cnt >= CNT_W'(SLEEP_CYCLES)) next_state = PDMMIC_SLEEP;
                else if (wake_cnt >= 32'(WAKE_CNT - 1)) next_state = PDMMIC_RUN;
            end
            PDMMIC_RUN: begin
                if (period_cnt >= CNT_W'(SLEEP_CYCLES)) next_state = PDMMIC_SLEEP;
            end
            default: next_state = PDMMIC_SLEEP;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lk_s1       <= 1'b0;
            lk_s2       <= 1'b0;
            lk_s3       <= 1'b0;
            period_cnt  <= '0;
            last_period <= '0;
            wake_cnt    <= '0;
            low_power   <= 1'b0;
            state       <= PDMMIC_SLEEP;
        end else begin
            lk_s1       <= i_link_clk;
            lk_s2       <= lk_s1;
            lk_s3       <= lk_s2;
            period_cnt  <= next_period_cnt;
            last_period <= next_last_period;
            wake_cnt    <= next_wake_cnt;
            low_power   <= next_low_power;
            state       <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Two-entry sample buffer and sigma-delta modulator
    // ------------------------------------------------------------------
    logic [SAMP_W-1:0] buf_mem [2];
    logic [SAMP_W-1:0] next_buf0, next_buf1;
    logic [1:0]        buf_cnt, next_buf_cnt;
    logic              take, push;
    logic [SAMP_W:0]   acc, next_acc;
    logic [SAMP_W-1:0] cur, next_cur;
    logic              bit_q, next_bit_q;
    logic              tog_sys, next_tog_sys;
    logic              ack_s1, ack_s2, ack_s3;
    logic              run_q;
    logic              lk_tog;

    // New bit wanted once per link period (acknowledged edge)
    assign take = ack_s2 ^ ack_s3;
    assign push = i_sample_valid && (buf_cnt != 2'h2);

    always_comb begin
        next_buf0    = buf_mem[0];
        next_buf1    = buf_mem[1];
        next_buf_cnt = buf_cnt;
        next_cur     = cur;
        next_acc     = acc;
        next_bit_q   = bit_q;
        next_tog_sys = tog_sys;
        if (take) begin
            // Pop a fresh sample when present; otherwise hold the last one
            if (buf_cnt != 2'h0) begin
                next_cur  = buf_mem[0];
                next_buf0 = buf_mem[1];
            end
            // First-order modulator: midscale gives alternating bits, density of ones tracks amplitude
            next_acc     = {1'b0, acc[SAMP_W-1:0]} + {1'b0, next_cur} + {1'b0, OFFSET_CODE};
            next_bit_q   = next_acc[SAMP_W];
            next_tog_sys = ~tog_sys;
        end
        case ({push, take && (buf_cnt != 2'h0)})
            2'b10: begin
                if (buf_cnt == 2'h0) next_buf0 = i_sample;
                else next_buf1 = i_sample;
                next_buf_cnt = buf_cnt + 2'h1;
            end
            2'b01: next_buf_cnt = buf_cnt - 2'h1;
            2'b11: begin
                if (buf_cnt == 2'h1) next_buf0 = i_sample;
                else next_buf1 = i_sample;
            end
            default: next_buf_cnt = buf_cnt;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            buf_mem[0] <= '0;
            buf_mem[1] <= '0;
            buf_cnt    <= '0;
            cur        <= {1'b1, {(SAMP_W-1){1'b0}}};
            acc        <= '0;
            bit_q      <= 1'b0;
            tog_sys    <= 1'b0;
            ack_s1     <= 1'b0;
            ack_s2     <= 1'b0;
            ack_s3     <= 1'b0;
            run_q      <= 1'b0;
            o_sample_ready        <= 1'b0;
            o_left_slot           <= 1'b0;
            o_low_power_operation <= 1'b0;
            o_awake               <= 1'b0;
        end else begin
            buf_mem[0] <= next_buf0;
            buf_mem[1] <= next_buf1;
            buf_cnt    <= next_buf_cnt;
            cur        <= next_cur;
            acc        <= next_acc;
            bit_q      <= next_bit_q;
            tog_sys    <= next_tog_sys;
            ack_s1     <= lk_tog;
            ack_s2     <= ack_s1;
            ack_s3     <= ack_s2;
            run_q      <= (next_state == PDMMIC_RUN);
            o_sample_ready        <= (next_buf_cnt != 2'h2);
            o_left_slot           <= next_left_slot;
            o_low_power_operation <= next_low_power;
            o_awake               <= (next_state == PDMMIC_RUN);
        end
    end

    // ------------------------------------------------------------------
    // Link domain: launch on slot edge, release on the other edge
    // ------------------------------------------------------------------
    logic rb_s1, rb_s2, rs_s1, rs_s2, rl_s1, rl_s2;
    logic r_data, r_oe, f_data, f_oe;
    logic right_slot_output, left_slot_output;
    logic r_oe_l, f_oe_r, high_half;

    // Rising edge: right slot launches, left slot releases; also requests next bit
    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rb_s1  <= 1'b0;
            rb_s2  <= 1'b0;
            rs_s1  <= 1'b0;
            rs_s2  <= 1'b0;
            rl_s1  <= 1'b0;
            rl_s2  <= 1'b0;
            lk_tog <= 1'b0;
            r_data <= 1'b0;
            r_oe   <= 1'b0;
        end else begin
            rb_s1  <= bit_q;
            rb_s2  <= rb_s1;
            rs_s1  <= run_q;
            rs_s2  <= rs_s1;
            rl_s1  <= left_slot;
            rl_s2  <= rl_s1;
            lk_tog <= ~lk_tog;
            r_data <= rb_s2;
            r_oe   <= rs_s2 && !rl_s2;
        end
    end

    // Falling edge: left slot launches, right slot releases
    always_ff @(negedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            f_data <= 1'b0;
            f_oe   <= 1'b0;
        end else begin
            f_data <= rb_s2;
            f_oe   <= rs_s2 && rl_s2;
        end
    end

    // Each enable is cleared by the opposite edge's flop, so the line is released for the other half
    assign right_slot_output = r_data;
    assign left_slot_output  = f_data;
    assign o_data_out = rl_s2 ? left_slot_output : right_slot_output;
    // Phase flops differ only in the high half; asleep the enable is cut at once, even with a stopped clock
    assign high_half  = r_oe_l ^ f_oe_r;
    assign o_data_oe  = run_q & (rl_s2 ? (f_oe & ~high_half) : (r_oe & high_half));

    // Release masks: the launching edge drives, the opposite edge ends the half
    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) r_oe_l <= 1'b0;
        else r_oe_l <= ~r_oe_l;
    end
    always_ff @(negedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) f_oe_r <= 1'b0;
        else f_oe_r <= r_oe_l;
    end
endmodule : pdmmic_out

// ==== src/pdmmic_pkg.sv ====
// Function
// - A left-slot device launches each new bit on the falling edge of the link clock.
// - A right-slot device launches each new bit on the rising edge of the link clock.
// - After driving its bit during its own half period, the device releases the data line.
// - A lone device drives only on its own slot edge, so a left device never drives on a rising edge.
// - The channel strap is captured once after reset and held; the outside party keeps it steady.
// - Strap low selects the right slot (rising edge), strap high selects the left slot (falling edge).
// - Each slot carries one modulator bit per clock period with no framing.
// - Amplitude is the density of ones; the receiver decodes on that basis.
// - A zero-level input gives an alternating one/zero pattern.
// - The stream carries a constant offset of about three percent of full scale.
// - A link clock below the sleep threshold puts the device to sleep with its output released.
// - After the clock returns from sleep, valid data resumes after the wake-up interval.
// - A link clock at the low-power rate selects low-power operation.
package pdmmic_pkg;
    // ------------------------------------------------------------------
    // Timing, sample format, strap polarity and state encoding
    // ------------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ       = 100_000_000;
    localparam int unsigned SLEEP_FREQ_HZ    = 200_000;
    localparam int unsigned LOWPWR_MAX_HZ    = 800_000;
    localparam int unsigned WAKE_TIME_MS     = 7;
    // Longest link period still awake: rounded down
    localparam int unsigned SLEEP_CYCLES     = SYS_CLK_HZ / SLEEP_FREQ_HZ;
    // Shortest period that still counts as low power
    localparam int unsigned LOWPWR_CYCLES    = SYS_CLK_HZ / LOWPWR_MAX_HZ;
    localparam int unsigned WAKE_CYCLES      = (SYS_CLK_HZ / 1000) * WAKE_TIME_MS;
    // Offset in whole percent of the 32768-code full-scale swing: 3 percent of half the 16-bit range
    localparam int unsigned OFFSET_PERCENT   = 3;
    localparam int unsigned SAMPLE_W         = 16;
    localparam logic [15:0] OFFSET_CODE      = 16'((65536 * OFFSET_PERCENT) / 200);
    localparam logic        STRAP_RIGHT      = 1'h0;
    localparam int unsigned CNT_W            = 20;

    typedef enum logic [1:0] {
        PDMMIC_SLEEP = 2'b00,
        PDMMIC_WAKE  = 2'b01,
        PDMMIC_RUN   = 2'b10
    } pdmmic_state_t;
endpackage : pdmmic_pkg

// ==== testbench/pdm_microphone_output_test.sv ====
module pdm_microphone_output_test;
    import pdmmic_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned WAKE_SIM = 50;
    logic        i_clk = 0, i_rst_n = 0, i_strap = 0, i_sample_valid = 1, run = 1, left = 0;
    logic        o_sample_ready, o_data_out, o_data_oe, o_left_slot, o_low_power_operation, o_awake, link_clk;
    logic [15:0] i_sample = 16'h8000, half_ns = 16'h0020, bits, ones, flips, miss, d_o, d_f, d_m;
    int          n_errors = 0, samples_checked = 0, cycles = 0, n_acc = 0;

    pdmmic_out #(.WAKE_CNT(WAKE_SIM)) i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_link_clk(link_clk),
        .i_strap(i_strap), .i_sample(i_sample), .i_sample_valid(i_sample_valid), .o_sample_ready(o_sample_ready),
        .o_data_out(o_data_out), .o_data_oe(o_data_oe), .o_left_slot(o_left_slot),
        .o_low_power_operation(o_low_power_operation), .o_awake(o_awake));
    pdmmic_codec_model i_codec (.i_run(run), .i_left(left), .i_half_ns(half_ns), .i_data(o_data_out),
        .i_oe(o_data_oe), .o_link_clk(link_clk), .o_bits(bits), .o_ones(ones), .o_flips(flips), .o_miss(miss));

    // ----------------------------------------
    // Clock, accept counter and hang guard
    // ----------------------------------------
    initial begin
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cycles++;
        if (i_sample_valid && o_sample_ready) n_acc++;
        if (cycles == 20000) begin
            n_errors++;
            final_report();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
        samples_checked++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask : check
    task automatic collect(input int n);
        logic [15:0] b0, o0, f0, m0;
        {b0, o0, f0, m0} = {bits, ones, flips, miss};
        repeat (n * 20) if (16'(bits - b0) < n) @(negedge i_clk);
        {d_o, d_f, d_m} = {16'(ones - o0), 16'(flips - f0), 16'(miss - m0)};
    endtask : collect
    task automatic wait_awake();
        repeat (300) if (o_awake !== 1'b1) @(negedge i_clk);
        check(16'(o_awake), 16'h0001, 16'h0001);
    endtask : wait_awake

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_slot(input logic strap);
        @(negedge i_clk);
        {i_strap, left, i_rst_n, i_sample} = {strap, strap, 1'b0, 16'h8000};
        repeat (5) @(negedge i_clk);
        i_rst_n = 1;
        wait_awake();
        check(16'(o_left_slot), 16'(strap), 16'(strap));
        repeat (40) @(negedge i_clk);
        collect(200);
        check(d_m, 16'h0000, 16'h0000);
        check(d_f, 16'h00B4, 16'h00C8);
        check(d_o, 16'h0064, 16'h006A);
        i_strap = ~strap;
        repeat (20) @(negedge i_clk);
        check(16'(o_left_slot), 16'(strap), 16'(strap));
        i_strap = strap;
        $display("test_slot %0d done", strap);
    endtask : test_slot
    task automatic test_density();
        i_sample = 16'hFFFF;
        repeat (100) @(negedge i_clk);
        collect(100);
        check(d_o, 16'h005A, 16'h0064);
        i_sample = 16'h0000;
        repeat (100) @(negedge i_clk);
        collect(100);
        check(d_o, 16'h0000, 16'h000A);
        i_sample = 16'h8000;
        $display("test_density done");
    endtask : test_density
    task automatic test_buffer();
        i_sample_valid = 0;
        repeat (200) @(negedge i_clk);
        run = 0;
        repeat (20) @(negedge i_clk);
        n_acc = 0;
        i_sample_valid = 1;
        repeat (20) @(negedge i_clk);
        check(16'(n_acc), 16'h0002, 16'h0003);
        check(16'(o_sample_ready), 16'h0000, 16'h0000);
        run = 1;
        repeat (100) @(negedge i_clk);
        check(16'(n_acc), 16'h0004, 16'h00FF);
        $display("test_buffer done");
    endtask : test_buffer
    task automatic test_sleep();
        run = 0;
        repeat (600) @(negedge i_clk);
        check(16'(o_awake), 16'h0000, 16'h0000);
        check(16'(o_data_oe), 16'h0000, 16'h0000);
        run = 1;
        repeat (WAKE_SIM - 10) @(negedge i_clk);
        check(16'(o_awake), 16'h0000, 16'h0000);
        wait_awake();
        $display("test_sleep done");
    endtask : test_sleep
    task automatic test_low_power();
        half_ns = 16'h02BC;
        repeat (3000) @(negedge i_clk);
        check(16'(o_low_power_operation), 16'h0001, 16'h0001);
        half_ns = 16'h0020;
        repeat (300) @(negedge i_clk);
        check(16'(o_low_power_operation), 16'h0000, 16'h0000);
        $display("test_low_power done");
    endtask : test_low_power

    task automatic final_report();
        $display("checks=%0d errors=%0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report

    // Main sequence
    initial begin
        test_slot(1'b0);
        test_density();
        test_buffer();
        test_sleep();
        test_low_power();
        test_slot(1'b1);
        final_report();
    end
endmodule : pdm_microphone_output_test

bind pdmmic_out pdmmic_out_monitor #(.WAKE_CNT(WAKE_CNT)) i_mon (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_link_clk(i_link_clk), .o_data_oe(o_data_oe), .o_left_slot(o_left_slot), .o_awake(o_awake));

// ==== testbench/pdmmic_codec_model.sv ====
// ----------------------------------------
// Codec side: link clock source and bit sampler
// ----------------------------------------
module pdmmic_codec_model (
    input  wire logic        i_run,
    input  wire logic        i_left,
    input  wire logic [15:0] i_half_ns,
    input  wire logic        i_data,
    input  wire logic        i_oe,
    output logic             o_link_clk,
    output logic [15:0]      o_bits,
    output logic [15:0]      o_ones,
    output logic [15:0]      o_flips,
    output logic [15:0]      o_miss
);
    timeunit 1ns;
    timeprecision 100ps;
    logic line_last = 1'b0;
    logic prev_bit  = 1'b0;
    // No pull resistor: a released line never shows the old bit
    wire  line = i_oe ? i_data : ~line_last;

    // Clock runs only while enabled, parked low otherwise
    initial begin
        {o_link_clk, o_bits, o_ones, o_flips, o_miss} = '0;
        #3;
        forever begin
            if (i_run) begin
                #(i_half_ns) o_link_clk = 1'b1;
                #(i_half_ns) o_link_clk = 1'b0;
            end else #7;
        end
    end

    // Last driven level
    always @(i_oe or i_data) if (i_oe) line_last = i_data;

    // Right bit taken before the fall, left bit before the rise
    always @(o_link_clk) begin
        if (o_link_clk != i_left) begin
            #(i_half_ns - 16'h0004);
            if (!i_oe) o_miss++;
            else begin
                o_bits++;
                o_ones += 16'(line);
                if (line != prev_bit) o_flips++;
                prev_bit = line;
            end
        end
    end
endmodule : pdmmic_codec_model

// ==== testbench/pdmmic_out_monitor.sv ====
// ----------------------------------------
// Slot timing and power-state checker
// ----------------------------------------
module pdmmic_out_monitor
    import pdmmic_pkg::*;
#(
    parameter int unsigned WAKE_CNT = WAKE_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_link_clk,
    input wire logic o_data_oe,
    input wire logic o_left_slot,
    input wire logic o_awake
);
    logic        link_q;
    logic [15:0] idle_cnt;
    logic [15:0] down_cnt;
    logic        next_link_q;
    logic [15:0] next_idle_cnt;
    logic [15:0] next_down_cnt;

    // Cycles since the last link rise, and cycles spent not awake
    always_comb begin
        next_link_q   = i_link_clk;
        next_idle_cnt = (i_link_clk && !link_q) ? 16'h0000 : idle_cnt + 16'h0001;
        next_down_cnt = o_awake ? 16'h0000 : down_cnt + 16'h0001;
    end

    // Counter registers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            link_q   <= 1'b0;
            idle_cnt <= 16'h0000;
            down_cnt <= 16'h0000;
        end else begin
            link_q   <= next_link_q;
            idle_cnt <= next_idle_cnt;
            down_cnt <= next_down_cnt;
        end
    end

    default clocking mon_cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_slot_held: assert property (o_awake |-> $stable(o_left_slot))
        else $error("slot changed while running");
    a_left_edge: assert property (o_left_slot && $rose(o_data_oe) |-> !i_link_clk)
        else $error("left drive began outside low phase");
    a_right_edge: assert property (!o_left_slot && $rose(o_data_oe) |-> i_link_clk)
        else $error("right drive began outside high phase");
    a_left_release: assert property (o_left_slot && o_awake && $rose(i_link_clk) |-> ##[0:3] !o_data_oe)
        else $error("left drive not released");
    a_right_release: assert property (!o_left_slot && o_awake && $fell(i_link_clk) |-> ##[0:3] !o_data_oe)
        else $error("right drive not released");
    a_sleep_quiet: assert property (!o_awake |-> !o_data_oe)
        else $error("driving while not awake");
    a_sleep_entry: assert property (idle_cnt > 16'h0208 |-> !o_awake)
        else $error("awake without link clock");
    a_wake_delay: assert property ($rose(o_awake) |-> down_cnt >= 16'(WAKE_CNT))
        else $error("woke before wake interval");
endmodule : pdmmic_out_monitor
